//--- core/bac_defines.svh
`ifndef BAC_DEFINES_SVH
`define BAC_DEFINES_SVH

// Register byte offsets
`define BAC_OFS_CTRL      4'h0
`define BAC_OFS_STAT      4'h4

// Control register reset value
`define BAC_CTRL_RESET    16'h0000

// Control field positions
`define BAC_BIT_ADDR_PU   15
`define BAC_BIT_DATA_PU   14
`define BAC_BIT_MEM_HIGH  13
`define BAC_BIT_STB_DRV   12
`define BAC_BIT_ENDIAN    11
`define BAC_POS_A0_BURST  9
`define BAC_POS_A5_BURST  7
`define BAC_POS_A6_BURST  5
`define BAC_POS_MEMTYPE   2
`define BAC_BIT_A5_CARD   1
`define BAC_BIT_A6_CARD   0

// Memory type codes for areas 2 and 3
`define BAC_MT_CODE_ORD   3'h0
`define BAC_MT_CODE_A3SD  3'h2
`define BAC_MT_CODE_BOTH  3'h3

// Bus width codes seen on the width inputs
`define BAC_W8            2'h1
`define BAC_W16           2'h2
`define BAC_W32           2'h3

// Status field positions
`define BAC_ST_INIT       0
`define BAC_ST_MT_BAD     1
`define BAC_ST_A0_CONF    2
`define BAC_ST_A5_CONF    3
`define BAC_ST_A6_CONF    4
`define BAC_ST_A23_WIDTH  5
`define BAC_ST_SD_RATIO   6
`define BAC_ST_END_VALID  7

// Address pull-up duration after bus acknowledge
`define BAC_PULLUP_CYC    3'h4

`endif

//--- core/bac_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "bac_defines.svh"
module bac_pin_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Link to the register bank
   bac_pin_if.pins  pif
);
   logic       ack_d_r;
   logic [2:0] pu_cnt_r;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ack_d_r  <= 1'b0;
         pu_cnt_r <= 3'h0;
      end else begin
         ack_d_r <= pif.bus_ack;
         if (pif.bus_ack && !ack_d_r && pif.addr_pu) begin
            pu_cnt_r <= `BAC_PULLUP_CYC;
         end else if (pu_cnt_r != 3'h0) begin
            pu_cnt_r <= pu_cnt_r - 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pif.addr_pullup_en <= 1'b0;
         pif.data_pullup_en <= 1'b0;
         pif.mem_pins_oe    <= 1'b0;
         pif.mem_pins_high  <= 1'b0;
         pif.strobe_pins_oe <= 1'b0;
      end else begin
         // Pull-up window opens on the second edge after acknowledge rises
         pif.addr_pullup_en <= (pu_cnt_r != 3'h0);
         pif.data_pullup_en <= pif.data_pu && pif.data_idle;
         pif.mem_pins_oe    <= !pif.standby || pif.mem_high;
         pif.mem_pins_high  <= pif.standby && pif.mem_high;
         pif.strobe_pins_oe <= !(pif.standby || pif.bus_ack) || pif.stb_drive;
      end
   end
endmodule
`default_nettype wire

//--- core/bac_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bac_pin_if;
   logic addr_pu;
   logic data_pu;
   logic mem_high;
   logic stb_drive;
   logic bus_ack;
   logic standby;
   logic data_idle;
   logic addr_pullup_en;
   logic data_pullup_en;
   logic mem_pins_oe;
   logic mem_pins_high;
   logic strobe_pins_oe;

   modport ctrl (
      output addr_pu, data_pu, mem_high, stb_drive, bus_ack, standby, data_idle,
      input  addr_pullup_en, data_pullup_en, mem_pins_oe, mem_pins_high,
      input  strobe_pins_oe
   );
   modport pins (
      input  addr_pu, data_pu, mem_high, stb_drive, bus_ack, standby, data_idle,
      output addr_pullup_en, data_pullup_en, mem_pins_oe, mem_pins_high,
      output strobe_pins_oe
   );
endinterface
`default_nettype wire

//--- core/bac_pkg.sv
package bac_pkg;
   typedef enum logic [1:0] {
      BAC_BURST_NONE,
      BAC_BURST_4,
      BAC_BURST_8,
      BAC_BURST_16
   } bac_burst_t;

   typedef enum logic [1:0] {
      BAC_MT_ORD,
      BAC_MT_A3SD,
      BAC_MT_BOTHSD
   } bac_memtype_t;
endpackage

//--- core/bac_top.sv
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bac_defines.svh"
module bac_top (
   // Clock and power-on reset
   input  wire logic               mclk,
   input  wire logic               rstn,
   // Avalon-MM slave
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   // Endian strap pin
   input  wire logic               endian_select_pin,
   // Bus state from the bus engines
   input  wire logic               bus_ack,
   input  wire logic               standby,
   input  wire logic               data_idle,
   input  wire logic               clk_ratio_one,
   input  wire logic [1:0]         area0_width,
   input  wire logic [1:0]         area2_width,
   input  wire logic [1:0]         area3_width,
   input  wire logic [1:0]         area5_width,
   input  wire logic [1:0]         area6_width,
   // Area configuration
   output bac_pkg::bac_burst_t     area0_burst,
   output bac_pkg::bac_burst_t     area5_burst,
   output bac_pkg::bac_burst_t     area6_burst,
   output bac_pkg::bac_memtype_t   area23_memtype,
   output logic                    area5_card_space,
   output logic                    area6_card_space,
   output logic                    endian_little,
   output logic                    area3_sdram_block,
   // Pin control
   output logic                    addr_pullup_en,
   output logic                    data_pullup_en,
   output logic                    mem_pins_oe,
   output logic                    mem_pins_high,
   output logic                    strobe_pins_oe
);
   import bac_pkg::*;

   // Control bits, endian flag held apart
   logic [15:0] ctrl_r;
   logic        endian_r;
   logic        end_valid_r;
   logic        end_s1_r;
   logic        end_s2_r;
   logic        fill1_r;
   logic        fill2_r;
   logic        init_r;
   logic        mt_bad_r;

   // Bus slave state
   logic        wait_r;
   logic [31:0] rdata_r;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        wr_go;

   // Live configuration checks
   logic        a0_conf;
   logic        a5_conf;
   logic        a6_conf;
   logic        a23_width;
   logic        sd_ratio;
   logic [15:0] ctrl_view;
   logic [7:0]  stat_view;
   logic [2:0]  mt_wr;
   logic        mt_wr_ok;

   // Registered outputs
   bac_burst_t   a0_burst_r;
   bac_burst_t   a5_burst_r;
   bac_burst_t   a6_burst_r;
   bac_memtype_t mt_r;
   logic         a5_card_r;
   logic         a6_card_r;
   logic         sd_block_r;

   bac_pin_if pif ();

   // Burst field to burst length code, used for three areas
   function automatic bac_burst_t burst_of(input logic [1:0] f);
      bac_burst_t b;
      b = BAC_BURST_NONE;
      unique case (f)
         2'h0: b = BAC_BURST_NONE;
         2'h1: b = BAC_BURST_4;
         2'h2: b = BAC_BURST_8;
         2'h3: b = BAC_BURST_16;
      endcase
      return b;
   endfunction

   // Burst length versus bus width; area 0 forbids 8 on 32 like the others
   function automatic logic burst_bad(input logic [1:0] f, input logic [1:0] w);
      logic bad;
      bad = 1'b0;
      unique case (f)
         2'h0: bad = 1'b0;
         2'h1: bad = 1'b0;
         2'h2: bad = (w == `BAC_W32);
         2'h3: bad = (w != `BAC_W8);
      endcase
      return bad;
   endfunction

   // Memory type code to type; only the three legal codes reach here
   function automatic bac_memtype_t mt_of(input logic [2:0] c);
      bac_memtype_t m;
      m = BAC_MT_ORD;
      if (c == `BAC_MT_CODE_A3SD) begin
         m = BAC_MT_A3SD;
      end else if (c == `BAC_MT_CODE_BOTH) begin
         m = BAC_MT_BOTHSD;
      end
      return m;
   endfunction

   // Address decode
   assign hit_ctrl = (avs_address == `BAC_OFS_CTRL);
   assign hit_stat = (avs_address == `BAC_OFS_STAT);

   // A write lands on the edge that sees waitrequest low
   assign wr_go = avs_write && !wait_r;

   // Incoming memory type field and its legality
   assign mt_wr    = avs_writedata[`BAC_POS_MEMTYPE +: 3];
   assign mt_wr_ok = (mt_wr == `BAC_MT_CODE_ORD) || (mt_wr == `BAC_MT_CODE_A3SD) ||
                     (mt_wr == `BAC_MT_CODE_BOTH);

   // Endian pin synchroniser
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         end_s1_r <= 1'b0;
         end_s2_r <= 1'b0;
      end else begin
         end_s1_r <= endian_select_pin;
         end_s2_r <= end_s1_r;
      end
   end

   // Strap capture waits until both stages hold the pin, not their reset zeros
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fill1_r     <= 1'b0;
         fill2_r     <= 1'b0;
         endian_r    <= 1'b0;
         end_valid_r <= 1'b0;
      end else begin
         fill1_r <= 1'b1;
         fill2_r <= fill1_r;
         if (fill2_r && !end_valid_r) begin
            endian_r    <= end_s2_r;
            end_valid_r <= 1'b1;
         end
      end
   end

   // Control register; only rstn clears it, there is no other reset here
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `BAC_CTRL_RESET;
      end else if (wr_go && hit_ctrl) begin
         if (avs_byteenable[1]) begin
            ctrl_r[15:12] <= avs_writedata[15:12];
            ctrl_r[11]    <= 1'b0;
            ctrl_r[10:8]  <= avs_writedata[10:8];
         end
         if (avs_byteenable[0]) begin
            ctrl_r[7:5] <= avs_writedata[7:5];
            ctrl_r[1:0] <= avs_writedata[1:0];
            // Prohibited memory type codes leave the old type in place
            if (mt_wr_ok) begin
               ctrl_r[`BAC_POS_MEMTYPE +: 3] <= mt_wr;
            end
         end
      end
   end

   // Software flags: init seen, and a refused memory type write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         init_r   <= 1'b0;
         mt_bad_r <= 1'b0;
      end else begin
         if (wr_go && hit_ctrl) begin
            init_r <= 1'b1;
         end
         // Set wins over a write-one clear in the same cycle
         if (wr_go && hit_ctrl && avs_byteenable[0] && !mt_wr_ok) begin
            mt_bad_r <= 1'b1;
         end else if (wr_go && hit_stat && avs_byteenable[0] &&
                      avs_writedata[`BAC_ST_MT_BAD]) begin
            mt_bad_r <= 1'b0;
         end
      end
   end

   // Width and clock ratio checks against the programmed bursts and memory type
   assign a0_conf   = burst_bad(ctrl_r[`BAC_POS_A0_BURST +: 2], area0_width);
   assign a5_conf   = burst_bad(ctrl_r[`BAC_POS_A5_BURST +: 2], area5_width);
   assign a6_conf   = burst_bad(ctrl_r[`BAC_POS_A6_BURST +: 2], area6_width);
   assign a23_width = (ctrl_r[`BAC_POS_MEMTYPE +: 3] == `BAC_MT_CODE_BOTH) &&
                      (area2_width != area3_width);
   assign sd_ratio  = (ctrl_r[`BAC_POS_MEMTYPE +: 3] != `BAC_MT_CODE_ORD) &&
                      clk_ratio_one;

   // Read views
   always_comb begin
      ctrl_view                  = ctrl_r;
      ctrl_view[`BAC_BIT_ENDIAN] = endian_r;
   end

   always_comb begin
      stat_view                     = 8'h00;
      stat_view[`BAC_ST_INIT]       = init_r;
      stat_view[`BAC_ST_MT_BAD]     = mt_bad_r;
      stat_view[`BAC_ST_A0_CONF]    = a0_conf;
      stat_view[`BAC_ST_A5_CONF]    = a5_conf;
      stat_view[`BAC_ST_A6_CONF]    = a6_conf;
      stat_view[`BAC_ST_A23_WIDTH]  = a23_width;
      stat_view[`BAC_ST_SD_RATIO]   = sd_ratio;
      stat_view[`BAC_ST_END_VALID]  = end_valid_r;
   end

   // One wait state per access: answer on the edge after the request
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wait_r <= 1'b1;
      end else if (wait_r) begin
         wait_r <= !(avs_read || avs_write);
      end else begin
         wait_r <= 1'b1;
      end
   end

   // Read data is loaded while waitrequest is high, so it stands at the answer edge
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read && wait_r) begin
         if (hit_ctrl) begin
            rdata_r <= {16'h0000, ctrl_view};
         end else if (hit_stat) begin
            rdata_r <= {24'h00_0000, stat_view};
         end else begin
            rdata_r <= 32'h0000_0000;
         end
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;

   // Area configuration outputs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         a0_burst_r <= BAC_BURST_NONE;
         a5_burst_r <= BAC_BURST_NONE;
         a6_burst_r <= BAC_BURST_NONE;
      end else begin
         a0_burst_r <= burst_of(ctrl_r[`BAC_POS_A0_BURST +: 2]);
         a5_burst_r <= burst_of(ctrl_r[`BAC_POS_A5_BURST +: 2]);
         a6_burst_r <= burst_of(ctrl_r[`BAC_POS_A6_BURST +: 2]);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mt_r       <= BAC_MT_ORD;
         a5_card_r  <= 1'b0;
         a6_card_r  <= 1'b0;
         sd_block_r <= 1'b0;
      end else begin
         mt_r       <= mt_of(ctrl_r[`BAC_POS_MEMTYPE +: 3]);
         a5_card_r  <= ctrl_r[`BAC_BIT_A5_CARD];
         a6_card_r  <= ctrl_r[`BAC_BIT_A6_CARD];
         // Area 3 SDRAM is fenced off while the clock ratio is 1:1 and an SDRAM memory type is programmed
         sd_block_r <= sd_ratio;
      end
   end

   assign area0_burst       = a0_burst_r;
   assign area5_burst       = a5_burst_r;
   assign area6_burst       = a6_burst_r;
   assign area23_memtype    = mt_r;
   assign area5_card_space  = a5_card_r;
   assign area6_card_space  = a6_card_r;
   assign area3_sdram_block = sd_block_r;
   assign endian_little     = endian_r;

   // Pin control
   assign pif.addr_pu   = ctrl_r[`BAC_BIT_ADDR_PU];
   assign pif.data_pu   = ctrl_r[`BAC_BIT_DATA_PU];
   assign pif.mem_high  = ctrl_r[`BAC_BIT_MEM_HIGH];
   assign pif.stb_drive = ctrl_r[`BAC_BIT_STB_DRV];
   assign pif.bus_ack   = bus_ack;
   assign pif.standby   = standby;
   assign pif.data_idle = data_idle;

   bac_pin_ctrl u_pins (
      .mclk (mclk),
      .rstn (rstn),
      .pif  (pif.pins)
   );

   assign addr_pullup_en = pif.addr_pullup_en;
   assign data_pullup_en = pif.data_pullup_en;
   assign mem_pins_oe    = pif.mem_pins_oe;
   assign mem_pins_high  = pif.mem_pins_high;
   assign strobe_pins_oe = pif.strobe_pins_oe;
endmodule
`default_nettype wire

//--- test/bac_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module bac_bus_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Bench requests
   input  wire logic       rel_req,
   input  wire logic       sby_req,
   input  wire logic       slow,
   input  wire logic [1:0] w_sel,
   // Bus state toward the block
   output logic            bus_ack,
   output logic            standby,
   output logic            data_idle,
   output logic [1:0]      area0_width,
   output logic [1:0]      area2_width,
   output logic [1:0]      area3_width,
   output logic [1:0]      area5_width,
   output logic [1:0]      area6_width
);
   logic [3:0] ack_q_r;
   logic [3:0] sby_q_r;
   logic [2:0] idle_r;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ack_q_r <= 4'h0;
         sby_q_r <= 4'h0;
         idle_r  <= 3'h0;
      end else begin
         ack_q_r <= {ack_q_r[2:0], rel_req};
         sby_q_r <= {sby_q_r[2:0], sby_req};
         idle_r  <= idle_r + 3'h1;
      end
   end
   // A slow far side answers three cycles later
   assign bus_ack     = slow ? ack_q_r[3] : ack_q_r[0];
   assign standby     = slow ? sby_q_r[3] : sby_q_r[0];
   assign data_idle   = idle_r[2] ^ idle_r[0];
   assign area0_width = w_sel;
   assign area2_width = w_sel;
   assign area3_width = w_sel;
   assign area5_width = w_sel;
   assign area6_width = w_sel;
endmodule
`default_nettype wire

//--- test/bac_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bac_top_asserts (
   // Clock and reset
   input wire logic                mclk,
   input wire logic                rstn,
   // Register bus
   input wire logic [3:0]          avs_address,
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic [31:0]         avs_writedata,
   input wire logic [3:0]          avs_byteenable,
   input wire logic                avs_waitrequest,
   // Bus state
   input wire logic                bus_ack,
   input wire logic                standby,
   input wire logic                data_idle,
   input wire logic                clk_ratio_one,
   // Configuration and pin control
   input wire bac_pkg::bac_burst_t area0_burst,
   input wire bac_pkg::bac_burst_t area5_burst,
   input wire bac_pkg::bac_burst_t area6_burst,
   input wire logic                area5_card_space,
   input wire logic                area6_card_space,
   input wire logic                endian_little,
   input wire logic                area3_sdram_block,
   input wire logic                addr_pullup_en,
   input wire logic                data_pullup_en,
   input wire logic                mem_pins_oe,
   input wire logic                mem_pins_high,
   input wire logic                strobe_pins_oe
);
   import bac_pkg::*;
   logic [2:0]  cnt_r;
   logic [15:0] wd_r;
   logic        up;
   logic        acc;
   assign up  = cnt_r == 3'h4;
   assign acc = avs_write && !avs_waitrequest && avs_address == 4'h0;
   // Past values are meaningless for a few edges after reset; the strap settles on edge 3
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         cnt_r <= 3'h0;
      else if (!up)
         cnt_r <= cnt_r + 3'h1;
   end
   always_ff @(posedge mclk) begin
      if (acc)
         wd_r <= avs_writedata[15:0];
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_wait_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("late bus answer");
   property p_lane0;
      acc && avs_byteenable[0] |-> ##2 area6_card_space == wd_r[0]
         && area5_card_space == wd_r[1] && area6_burst == wd_r[6:5];
   endproperty
   a_lane0: assert property (p_lane0) else $error("low lane config wrong");
   property p_lane1;
      acc && (&avs_byteenable[1:0]) |-> ##2 area0_burst == wd_r[10:9] && area5_burst == wd_r[8:7];
   endproperty
   a_lane1: assert property (p_lane1) else $error("burst config wrong");
   property p_endian;
      up |-> $stable(endian_little);
   endproperty
   a_endian: assert property (p_endian) else $error("endian flag moved");
   property p_pullup;
      $rose(addr_pullup_en) |-> addr_pullup_en [*4] ##1 !addr_pullup_en;
   endproperty
   a_pullup: assert property (p_pullup) else $error("address pull-up length");
   property p_data_pu;
      data_pullup_en |-> $past(data_idle);
   endproperty
   a_data_pu: assert property (p_data_pu) else $error("data pull-up while busy");
   property p_mem_pins;
      up && !$past(standby) |-> mem_pins_oe && !mem_pins_high;
   endproperty
   a_mem_pins: assert property (p_mem_pins) else $error("memory pins off outside standby");
   property p_strobe;
      up && !$past(standby) && !$past(bus_ack) |-> strobe_pins_oe;
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobes undriven on owned bus");
   property p_sdram;
      area3_sdram_block |-> $past(clk_ratio_one);
   endproperty
   a_sdram: assert property (p_sdram) else $error("sdram block without 1:1 ratio");
endmodule
bind bac_top bac_top_asserts u_chk (.mclk, .rstn, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_waitrequest, .bus_ack, .standby, .data_idle,
   .clk_ratio_one, .area0_burst, .area5_burst, .area6_burst, .area5_card_space,
   .area6_card_space, .endian_little, .area3_sdram_block, .addr_pullup_en,
   .data_pullup_en, .mem_pins_oe, .mem_pins_high, .strobe_pins_oe);
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bac_pkg::*;
   logic         mclk, rstn, avs_read, avs_write, avs_waitrequest, b, prev;
   logic [3:0]   avs_address, avs_byteenable, be;
   logic [31:0]  avs_writedata, avs_readdata, rd, wd, got;
   logic         endian_select_pin, bus_ack, standby, data_idle, clk_ratio_one;
   logic [1:0]   area0_width, area2_width, area3_width, area5_width, area6_width, w_sel;
   bac_burst_t   area0_burst, area5_burst, area6_burst;
   bac_memtype_t area23_memtype;
   logic         area5_card_space, area6_card_space, endian_little, area3_sdram_block;
   logic         addr_pullup_en, data_pullup_en, mem_pins_oe, mem_pins_high, strobe_pins_oe;
   logic         rel_req, sby_req, slow;
   logic [15:0]  exp_r;
   int           fail_count, samples_checked, seed, n_pu;

   bac_top dut (.mclk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .endian_select_pin, .bus_ack,
      .standby, .data_idle, .clk_ratio_one, .area0_width, .area2_width, .area3_width,
      .area5_width, .area6_width, .area0_burst, .area5_burst, .area6_burst,
      .area23_memtype, .area5_card_space, .area6_card_space, .endian_little,
      .area3_sdram_block, .addr_pullup_en, .data_pullup_en, .mem_pins_oe,
      .mem_pins_high, .strobe_pins_oe);
   bac_bus_model far (.mclk, .rstn, .rel_req, .sby_req, .slow, .w_sel, .bus_ack,
      .standby, .data_idle, .area0_width, .area2_width, .area3_width, .area5_width,
      .area6_width);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic end_of_test();
      $display("checked %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdat,
                      input logic [3:0] ben, output logic [31:0] rdat);
      int n;
      @(posedge mclk);
      avs_address <= addr;
      avs_writedata <= wdat;
      avs_byteenable <= ben;
      avs_read <= !wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         fail_count++;
         end_of_test();
      end
   endtask

   // Bit 11 is read-only and a prohibited memory type code leaves the field alone
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] w,
                                         input logic [1:0] ben);
      logic [15:0] n;
      n = old;
      if (ben[0]) n[7:0] = w[7:0];
      if (ben[1]) n[15:8] = w[15:8];
      if (!(n[4:2] inside {3'h0, 3'h2, 3'h3})) n[4:2] = old[4:2];
      n[11] = old[11];
      return n;
   endfunction

   function automatic logic [31:0] cfg_exp(input logic [15:0] e, input logic r);
      bac_memtype_t mt;
      mt = (e[4:2] == 3'h3) ? BAC_MT_BOTHSD : (e[4:2] == 3'h2) ? BAC_MT_A3SD : BAC_MT_ORD;
      return 32'({e[10:5], mt, e[1:0], e[4:2] != 3'h0 && r});
   endfunction

   // Burst against width: 8 needs an 8- or 16-bit bus, 16 needs an 8-bit bus
   function automatic logic bst_bad(input logic [1:0] f, input logic [1:0] w);
      return (f == 2'h2 && w == 2'h3) || (f == 2'h3 && w != 2'h1);
   endfunction

   function automatic logic [31:0] st_exp(input logic [15:0] e, input logic mb, input logic r,
                                          input logic [1:0] w);
      return {24'h0, 1'b1, e[4:2] != 3'h0 && r, 1'b0, bst_bad(e[6:5], w),
              bst_bad(e[8:7], w), bst_bad(e[10:9], w), mb, 1'b1};
   endfunction

   initial begin
      seed = 3058;
      fail_count = 0;
      samples_checked = 0;
      {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
      {rel_req, sby_req, slow, clk_ratio_one} = 4'h0;
      w_sel = 2'h1; // Byte-wide bus keeps every burst length legal
      endian_select_pin = 1'b1;
      rstn = 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      exp_r = 16'h0800;
      check("endian", 32'(endian_little), 32'h1);
      bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
      check("ctrl_reset", rd, 32'h0800);
      $display("test reset done");
      // Configuration is written before the far side is exercised
      for (int i = 0; i < 24; i++) begin
         wd = $random(seed);
         wd[10:2] = {i[1:0], i[1:0] + 2'h1, i[1:0] + 2'h2, i[2:0]};
         be = (i < 8) ? 4'hf : 4'($random(seed));
         clk_ratio_one <= 1'($random(seed));
         bus(1'b1, 4'h0, wd, be, rd);
         exp_r = merge(exp_r, wd[15:0], be[1:0]);
         bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
         check("ctrl", rd, {16'h0, exp_r});
         got = 32'({area0_burst, area5_burst, area6_burst, area23_memtype,
            area5_card_space, area6_card_space, area3_sdram_block});
         check("cfg", got, cfg_exp(exp_r, clk_ratio_one));
      end
      bus(1'b0, 4'h8, 32'h0, 4'h0, rd);
      check("unmapped", rd, 32'h0);
      // A prohibited memory type is refused and flagged; writing one clears the flag
      w_sel <= 2'h3;
      bus(1'b1, 4'h0, 32'h14, 4'h1, rd);
      exp_r = merge(exp_r, 16'h0014, 2'h1);
      for (int i = 1; i >= 0; i--) begin
         bus(1'b0, 4'h4, 32'h0, 4'h0, rd);
         check("status", rd, st_exp(exp_r, i[0], clk_ratio_one, 2'h3));
         bus(1'b1, 4'h4, 32'h2, 4'h1, rd);
      end
      bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
      check("ctrl_refused", rd, {16'h0, exp_r});
      $display("test registers done");
      for (int i = 0; i < 2; i++) begin
         b = i[0];
         bus(1'b1, 4'h0, {16'h0, b, b, b, b, 12'h000}, 4'h2, rd);
         exp_r = merge(exp_r, {b, b, b, b, 12'h000}, 2'h2);
         slow <= b;
         n_pu = 0;
         @(posedge mclk);
         prev = data_idle;
         rel_req <= 1'b1;
         for (int k = 0; k < 14; k++) begin
            @(posedge mclk);
            if (addr_pullup_en === 1'b1) n_pu++;
            check("data_pull", 32'(data_pullup_en), 32'(b & prev));
            prev = data_idle;
         end
         check("addr_pull", 32'(n_pu), b ? 32'h4 : 32'h0);
         check("strobe_rel", 32'(strobe_pins_oe), 32'(b));
         rel_req <= 1'b0;
         sby_req <= 1'b1;
         repeat (8) @(posedge mclk);
         check("standby", 32'({mem_pins_oe, mem_pins_high, strobe_pins_oe}), {29'h0, b, b, b});
         sby_req <= 1'b0;
         repeat (8) @(posedge mclk);
         check("awake", 32'({mem_pins_oe, mem_pins_high, strobe_pins_oe}), 32'h5);
      end
      $display("test pins done");
      endian_select_pin <= 1'b0;
      rstn <= 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      check("endian_again", 32'(endian_little), 32'h0);
      bus(1'b0, 4'h0, 32'h0, 4'h0, rd);
      check("ctrl_again", rd, 32'h0);
      $display("test reinit done");
      end_of_test();
   end
endmodule
`default_nettype wire
